// ### dv/tb_acs_sequencer.sv
// Purpose: Self-checking bench of the converter sequencer through its bus and analog-side ports.
// Assumes: clk 50 MHz, rst asynchronous active high, one wait cycle on every bus access.
// Notes:   The comparator is held constant per conversion so results are known exactly.
`timescale 1ns/100ps
`include "acs_map.svh"

module tb_acs_sequencer;
  import acs_pkg::*;

  logic        clk;
  logic        rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cmp_in;
  logic [13:0] tbl_addr;
  logic [7:0]  tbl_data_q;
  logic        pwr_en_q;
  logic        sample_q;
  logic [11:0] dac_code_q;
  logic [3:0]  ch_sel_q;
  logic [2:0]  src_sel_q;
  logic [2:0]  ref_en_q;
  logic        irq_q;
  int          n_fail;
  int          tests_run;
  int          cyc;
  logic [31:0] rd;

  acs_sequencer i_acs_sequencer (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in),
    .tbl_addr(tbl_addr), .tbl_data_q(tbl_data_q), .pwr_en_q(pwr_en_q), .sample_q(sample_q),
    .dac_code_q(dac_code_q), .ch_sel_q(ch_sel_q), .src_sel_q(src_sel_q),
    .ref_en_q(ref_en_q), .irq_q(irq_q)
  );

  // ---------------------------------------------------------------------------
  // Clock, timeout and closing report
  // ---------------------------------------------------------------------------
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The longest scenario is a few hundred cycles, so a hang shows long before this ceiling.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks made %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      n_fail = n_fail + 1;
    end
  endtask

  // A clock edge passes before each request so the strobe never toggles twice in one step.
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic tbl_chk(input logic [13:0] a, input logic [7:0] e);
    @(posedge clk);
    tbl_addr <= a;
    @(posedge clk);
    #1;
    chk("tbl_data_q", {24'h0, e}, {24'h0, tbl_data_q});
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("waitrequest", 1, avs_waitrequest);
    chk("ref_en_q", 3'b001, ref_en_q);
    chk("pwr irq", 0, {pwr_en_q, sample_q, irq_q});
    bus_rd(6'h20, rd);
    chk("unmapped read", 0, rd);
    $display("test reset done");
  endtask

  task automatic t_ref();
    logic [2:0] exp_en [4] = '{3'b001, 3'b010, 3'b100, 3'b010};
    for (int i = 0; i < 4; i++) begin
      bus_wr(`ACS_OFF_CTRL1, {i[1:0], 3'b011, 3'b000});
      #1;
      chk("ref_en_q", exp_en[i], ref_en_q);
    end
    bus_wr(`ACS_OFF_CTRL1, {2'b11, `ACS_SRC_BAD, 3'b000});
    #1;
    chk("src_sel_q kept", 3'b011, src_sel_q);
    $display("test reference done");
  endtask

  task automatic conv(input logic [2:0] ck, input logic [2:0] src, input logic fmt,
                      input logic c, input logic [7:0] ehi, input logic [7:0] elo);
    int r;
    int n;
    int tot;
    logic [3:0] ch;
    r = 1 << ck;
    tot = ((src == `ACS_SRC_TEMP) ? 58 : 16) * r;
    // Internal sources need the channel parked on a missing pin before the source changes.
    ch = (src == `ACS_SRC_TEMP) ? 4'hc : 4'h5;
    @(posedge clk);
    cmp_in <= c;
    bus_wr(`ACS_OFF_CTRL0, {ch, fmt, 3'b000});
    bus_wr(`ACS_OFF_CTRL1, {2'b01, src, ck});
    bus_wr(`ACS_OFF_INTC, 8'h07);
    bus_wr(`ACS_OFF_CTRL0, {ch, fmt, 3'b101});
    bus_wr(`ACS_OFF_CTRL0, {ch, fmt, 3'b100});
    #1;
    chk("sample_q at start", 1, sample_q);
    chk("ch_sel_q", ch, ch_sel_q);
    n = 0;
    while (sample_q === 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("sampling cycles", ((src == `ACS_SRC_TEMP) ? 46 : 4) * r, n);
    chk("dac_code_q", `ACS_SAR_MID, dac_code_q);
    while (irq_q !== 1'b1 && n < 8000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // The interrupt is registered from the next flag value, so it rises with the busy fall.
    chk("total cycles", tot, n);
    bus_rd(`ACS_OFF_CTRL0, rd);
    chk("busy after", 0, rd[`ACS_B_BUSY]);
    bus_rd(`ACS_OFF_RES_HI, rd);
    chk("result high", ehi, rd);
    bus_rd(`ACS_OFF_RES_LO, rd);
    chk("result low", elo, rd);
    bus_wr(`ACS_OFF_INTC, 8'h01);
    #1;
    chk("irq masked", 0, irq_q);
    bus_rd(`ACS_OFF_INTC, rd);
    chk("flag held", 8'h05, rd);
    bus_wr(`ACS_OFF_INTC, 8'h07);
    bus_rd(`ACS_OFF_INTC, rd);
    chk("flag cleared", 8'h03, rd);
    $display("test conversion ckdiv %0d done", ck);
  endtask

  task automatic t_abort();
    bus_wr(`ACS_OFF_CTRL1, {2'b01, 3'b000, 3'b011});
    bus_wr(`ACS_OFF_INTC, 8'h07);
    bus_wr(`ACS_OFF_CTRL0, 8'h55);
    bus_wr(`ACS_OFF_CTRL0, 8'h54);
    bus_rd(`ACS_OFF_CTRL0, rd);
    chk("busy during", 1, rd[`ACS_B_BUSY]);
    bus_wr(`ACS_OFF_CTRL0, 8'h50);
    #1;
    chk("power off", 0, {pwr_en_q, sample_q});
    repeat (200) @(posedge clk);
    bus_rd(`ACS_OFF_INTC, rd);
    chk("no flag on abort", 8'h03, rd);
    bus_wr(`ACS_OFF_CTRL0, 8'h51);
    bus_wr(`ACS_OFF_CTRL0, 8'h50);
    #1;
    chk("no start unpowered", 0, sample_q);
    bus_rd(`ACS_OFF_CTRL0, rd);
    chk("busy unpowered", 0, rd[`ACS_B_BUSY]);
    $display("test abort done");
  endtask

  // Polling software leaves both interrupt enables off and watches the busy bit.
  task automatic t_poll();
    int k;
    bus_wr(`ACS_OFF_INTC, 8'h04);
    bus_wr(`ACS_OFF_CTRL0, 8'h55);
    bus_wr(`ACS_OFF_CTRL0, 8'h54);
    k = 0;
    rd = 32'h00000002;
    while (rd[`ACS_B_BUSY] !== 1'b0 && k < 100) begin
      bus_rd(`ACS_OFF_CTRL0, rd);
      k++;
    end
    chk("polls while busy", 1, k > 1);
    chk("polled busy", 0, rd[`ACS_B_BUSY]);
    chk("irq while polling", 0, irq_q);
    bus_rd(`ACS_OFF_INTC, rd);
    chk("flag by polling", 8'h04, rd);
    $display("test polling done");
  endtask

  task automatic t_table();
    int t1;
    int den;
    logic [7:0] hi;
    tbl_chk(`ACS_TBL_T2, 8'h00);
    bus_wr(`ACS_OFF_MAPC, 8'h01);
    tbl_chk(`ACS_TBL_T2, 8'h80);
    tbl_chk(`ACS_TBL_ADC2_HI, 8'h5a);
    tbl_chk(`ACS_TBL_ADC2_LO, 8'h05);
    bus_wr(`ACS_OFF_MAPC, 8'h00);
    tbl_chk(`ACS_TBL_ADC2_HI, 8'h00);
    bus_rd(`ACS_OFF_FCAL_HI, rd);
    chk("factory high", 8'h96, rd);
    hi = rd[7:0];
    t1 = (hi >= 8'h90) ? 85 : 175;
    chk("first cal temp", 85, t1);
    bus_rd(`ACS_OFF_FCAL_LO, rd);
    chk("factory low", 8'h30, rd);
    // The denominator wraps by a full code range when the first point is the hot one.
    den = {hi, rd[7:4]} - 12'h5a5;
    if (t1 == 175) begin
      den = den + 4096;
    end
    chk("slope denominator", 12'h3be, den);
    $display("test table done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  // Inputs get values at time zero; reset is held for twelve cycles.
  initial begin
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    cmp_in = 1'b0;
    tbl_addr = 14'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_ref();
    conv(3'd0, 3'b000, 1'b0, 1'b1, 8'hff, 8'hf0);
    conv(3'd1, 3'b000, 1'b1, 1'b1, 8'h0f, 8'hff);
    conv(3'd2, 3'b000, 1'b0, 1'b0, 8'h00, 8'h00);
    conv(3'd3, 3'b000, 1'b0, 1'b1, 8'hff, 8'hf0);
    conv(3'd1, `ACS_SRC_TEMP, 1'b1, 1'b1, 8'h0f, 8'hff);
    t_abort();
    t_poll();
    t_table();
    end_of_test();
  end

endmodule

// ### shared/acs_map.svh
// Purpose: Register map, field positions and timing counts of the converter sequencer.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word.
// Notes:   Definitions only; include by bare name.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ACS_OFF_CTRL0     6'h00
`define ACS_OFF_CTRL1     6'h04
`define ACS_OFF_RES_HI    6'h08
`define ACS_OFF_RES_LO    6'h0c
`define ACS_OFF_INTC      6'h10
`define ACS_OFF_MAPC      6'h14
`define ACS_OFF_FCAL_HI   6'h18
`define ACS_OFF_FCAL_LO   6'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACS_B_START       0
`define ACS_B_BUSY        1
`define ACS_B_PWR         2
`define ACS_B_FMT         3
`define ACS_F_CH          7:4
`define ACS_F_CKDIV       2:0
`define ACS_F_SRC         5:3
`define ACS_F_REF         7:6
`define ACS_B_GIE         0
`define ACS_B_CIE         1
`define ACS_B_REQ         2
`define ACS_B_MAP         0

// ----------------------------------------------------------------------------
// Encodings, counts and table addresses
// ----------------------------------------------------------------------------
`define ACS_SRC_TEMP      3'b010
`define ACS_SRC_BAD       3'b111
`define ACS_REF_PIN       2'b00
`define ACS_REF_TEMP      2'b10
`define ACS_SAMP_EXT      6'd4
`define ACS_SAMP_TEMP     6'd46
`define ACS_TOTAL_EXT     6'd16
`define ACS_TOTAL_TEMP    6'd58
`define ACS_SAR_MSB       4'd11
`define ACS_SAR_MID       12'h800
`define ACS_TBL_T2        14'h3ff5
`define ACS_TBL_ADC2_HI   14'h3ff6
`define ACS_TBL_ADC2_LO   14'h3ff7

`endif

// ### shared/acs_pkg.sv
// Purpose: Types and shared helpers of the converter sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in acs_map.svh.
package acs_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {acs_idle, acs_sample, acs_conv} acs_state_t;

  // Converter clock ratio: select n divides the system clock by two to the n.
  function automatic logic [7:0] acs_ratio(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction

endpackage

// ### verilog/acs_sequencer.sv
// Purpose: Sequencer of a 12-bit successive-approximation converter with Avalon-MM registers.
// Assumes: clk at 50 MHz, rst asynchronous active high, comparator output from the analog side.
// Notes:   The analog front end (mux, DAC, comparator, references) sits outside this block.
//
// Overview of operation
// - Non-temperature inputs: four sampling, twelve converting, sixteen converter clocks.
// - Temperature sensor input: forty-six sampling plus twelve converting, fifty-eight total.
// - Conversion runs in hardware; the bus keeps answering meanwhile.
// - Power-enable low powers the converter down and stops any conversion.
// - Start written low, high, low: high resets converter, return low starts.
// - Busy stays high during conversion; at its fall the result bytes are valid.
// - Converter clock is system clock divided by two to the power of the three-bit select.
// - Two-bit field picks the reference; format bit picks result justification.
// - Reference code 01/11 supply, 10 temperature reference, 00 external pin.
// - Result is 12 bits; one step is the reference over 4096.
// - Code transitions sit half a step low; full scale one and a half low.
// - Table reads give T2 code at 3FF5H, ADC2 high at 3FF6H, low at 3FF7H.
// - Calibration table reads return data only while mapping is enabled.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "acs_map.svh"

module acs_sequencer
  import acs_pkg::*;
#(
  parameter logic [7:0]  T2_CODE   = 8'h80,   // Calibration defaults are arbitrary values.
  parameter logic [11:0] ADC2_VAL  = 12'h5a5,
  parameter logic [7:0]  FCAL_HI   = 8'h96,
  parameter logic [7:0]  FCAL_LO   = 8'h30
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        cmp_in,
  input  wire logic [13:0] tbl_addr,
  output logic      [7:0]  tbl_data_q,
  output logic             pwr_en_q,
  output logic             sample_q,
  output logic      [11:0] dac_code_q,
  output logic      [3:0]  ch_sel_q,
  output logic      [2:0]  src_sel_q,
  output logic      [2:0]  ref_en_q,
  output logic             irq_q
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic        wait_q, wait_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        fmt_q, fmt_d, start_q, start_d, pwr_d;
  logic [3:0]  ch_d;
  logic [2:0]  ckdiv_q, ckdiv_d, src_d, ref_en_d;
  logic [1:0]  ref_q, ref_d;
  logic        gie_q, gie_d, cie_q, cie_d, flag_q, flag_d, map_q, map_d, irq_d;
  logic [7:0]  tbl_d;
  logic        wr_take, ctl0_wr, start_set, start_go, done;
  logic [15:0] res_bytes;
  logic        cmp_m_q, cmp_s_q;
  acs_state_t  state_q, state_d;
  logic [6:0]  div_q, div_d;
  logic [5:0]  cnt_q, cnt_d, samp_len;
  logic [3:0]  bit_q, bit_d;
  logic [11:0] sar_q, sar_d, result_q, result_d, res_fin;
  logic        busy_q, busy_d, sample_d, tick;

  // Packs the result into high and low bytes by the format bit.
  function automatic logic [15:0] acs_pack(input logic [11:0] r, input logic f);
    return f ? {4'h0, r} : {r, 4'h0};
  endfunction

  assign avs_readdata    = {24'h000000, rdata_q};
  assign avs_waitrequest = wait_q;

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  // Every access waits one cycle, so read data is registered from a stable address.
  always_comb begin
    wr_take   = avs_write && !wait_q && avs_byteenable[0];
    ctl0_wr   = wr_take && avs_address == `ACS_OFF_CTRL0;
    start_set = ctl0_wr && avs_writedata[`ACS_B_START];
    start_go  = ctl0_wr && start_q && !avs_writedata[`ACS_B_START];
    res_bytes = acs_pack(result_q, fmt_q);
    wait_d    = !((avs_read || avs_write) && wait_q);
    rdata_d   = rdata_q;
    if ((avs_read || avs_write) && wait_q) begin
      case (avs_address)
        `ACS_OFF_CTRL0:   rdata_d = {ch_sel_q, fmt_q, pwr_en_q, busy_q, start_q};
        `ACS_OFF_CTRL1:   rdata_d = {ref_q, src_sel_q, ckdiv_q};
        `ACS_OFF_RES_HI:  rdata_d = res_bytes[15:8];
        `ACS_OFF_RES_LO:  rdata_d = res_bytes[7:0];
        `ACS_OFF_INTC:    rdata_d = {5'h00, flag_q, cie_q, gie_q};
        `ACS_OFF_MAPC:    rdata_d = {7'h00, map_q};
        `ACS_OFF_FCAL_HI: rdata_d = FCAL_HI;
        `ACS_OFF_FCAL_LO: rdata_d = FCAL_LO;
        default:          rdata_d = 8'h00;
      endcase
    end
    {ch_d, fmt_d, pwr_d, start_d} = {ch_sel_q, fmt_q, pwr_en_q, start_q};
    {ref_d, src_d, ckdiv_d} = {ref_q, src_sel_q, ckdiv_q};
    {gie_d, cie_d, map_d} = {gie_q, cie_q, map_q};
    if (ctl0_wr) begin
      start_d = avs_writedata[`ACS_B_START];
      pwr_d   = avs_writedata[`ACS_B_PWR];
      fmt_d   = avs_writedata[`ACS_B_FMT];
      ch_d    = avs_writedata[`ACS_F_CH];
    end
    if (wr_take && avs_address == `ACS_OFF_CTRL1) begin
      ckdiv_d = avs_writedata[`ACS_F_CKDIV];
      ref_d   = avs_writedata[`ACS_F_REF];
      // The forbidden source code is refused and the old source kept.
      if (avs_writedata[`ACS_F_SRC] != `ACS_SRC_BAD) begin
        src_d = avs_writedata[`ACS_F_SRC];
      end
    end
    if (wr_take && avs_address == `ACS_OFF_INTC) begin
      gie_d = avs_writedata[`ACS_B_GIE];
      cie_d = avs_writedata[`ACS_B_CIE];
    end
    if (wr_take && avs_address == `ACS_OFF_MAPC) begin
      map_d = avs_writedata[`ACS_B_MAP];
    end
    // Writing one clears the flag, but a completion in the same cycle wins.
    flag_d = flag_q;
    if (wr_take && avs_address == `ACS_OFF_INTC && avs_writedata[`ACS_B_REQ]) begin
      flag_d = 1'b0;
    end
    if (done) begin
      flag_d = 1'b1;
    end
    irq_d = flag_d && gie_d && cie_d;
    // Reference switches: {temperature, supply, pin}.
    case (ref_d)
      `ACS_REF_PIN:  ref_en_d = 3'b001;
      `ACS_REF_TEMP: ref_en_d = 3'b100;
      default:       ref_en_d = 3'b010;
    endcase
    tbl_d = 8'h00;
    if (map_q) begin
      case (tbl_addr)
        `ACS_TBL_T2:      tbl_d = T2_CODE;
        `ACS_TBL_ADC2_HI: tbl_d = ADC2_VAL[11:4];
        `ACS_TBL_ADC2_LO: tbl_d = {4'h0, ADC2_VAL[3:0]};
        default:          tbl_d = 8'h00;
      endcase
    end
  end

  // Register state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q     <= 1'b1;
      rdata_q    <= 8'h00;
      start_q    <= 1'b0;
      pwr_en_q   <= 1'b0;
      fmt_q      <= 1'b0;
      ch_sel_q   <= 4'h0;
      ckdiv_q    <= 3'h0;
      src_sel_q  <= 3'h0;
      ref_q      <= 2'h0;
      ref_en_q   <= 3'b001;
      gie_q      <= 1'b0;
      cie_q      <= 1'b0;
      flag_q     <= 1'b0;
      irq_q      <= 1'b0;
      map_q      <= 1'b0;
      tbl_data_q <= 8'h00;
    end else begin
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      start_q    <= start_d;
      pwr_en_q   <= pwr_d;
      fmt_q      <= fmt_d;
      ch_sel_q   <= ch_d;
      ckdiv_q    <= ckdiv_d;
      src_sel_q  <= src_d;
      ref_q      <= ref_d;
      ref_en_q   <= ref_en_d;
      gie_q      <= gie_d;
      cie_q      <= cie_d;
      flag_q     <= flag_d;
      irq_q      <= irq_d;
      map_q      <= map_d;
      tbl_data_q <= tbl_d;
    end
  end

  // --------------------------------------------------------------------------
  // Comparator synchroniser
  // --------------------------------------------------------------------------
  // The comparator is asynchronous to clk; at the fastest divider its decision
  // lags the DAC by two cycles, one reason slow dividers are recommended.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
    end else begin
      cmp_m_q <= cmp_in;
      cmp_s_q <= cmp_m_q;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  // The divider restarts at each start so every conversion has exact length.
  always_comb begin
    tick     = div_q == 7'(acs_ratio(ckdiv_q) - 8'h01);
    samp_len = (src_sel_q == `ACS_SRC_TEMP) ? `ACS_SAMP_TEMP : `ACS_SAMP_EXT;
    res_fin  = sar_q;
    res_fin[bit_q] = cmp_s_q;
    state_d  = state_q;
    div_d    = tick ? 7'h00 : div_q + 7'h01;
    cnt_d    = cnt_q;
    bit_d    = bit_q;
    sar_d    = sar_q;
    result_d = result_q;
    done     = 1'b0;
    case (state_q)
      acs_idle: begin
        div_d = 7'h00;
        if (start_go && avs_writedata[`ACS_B_PWR]) begin
          state_d = acs_sample;
          cnt_d   = 6'h00;
        end
      end
      acs_sample: begin
        if (tick) begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == samp_len - 6'h01) begin
            state_d = acs_conv;
            sar_d   = `ACS_SAR_MID;
            bit_d   = `ACS_SAR_MSB;
          end
        end
      end
      acs_conv: begin
        // One bit is decided per converter clock; the DAC adds the half-step offset.
        if (tick) begin
          sar_d = res_fin;
          if (bit_q == 4'h0) begin
            state_d  = acs_idle;
            result_d = res_fin;
            done     = 1'b1;
          end else begin
            bit_d = bit_q - 4'h1;
            sar_d[bit_q - 4'h1] = 1'b1;
          end
        end
      end
      default: state_d = acs_idle;
    endcase
    // Start held high or power removed resets the converter at once.
    if (start_set || !pwr_d) begin
      state_d = acs_idle;
      done    = 1'b0;
      sar_d   = 12'h000;
    end
    busy_d   = state_d != acs_idle;
    sample_d = state_d == acs_sample;
  end

  // Sequencer state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= acs_idle;
      div_q      <= 7'h00;
      cnt_q      <= 6'h00;
      bit_q      <= 4'h0;
      sar_q      <= 12'h000;
      result_q   <= 12'h000;
      busy_q     <= 1'b0;
      sample_q   <= 1'b0;
      dac_code_q <= 12'h000;
    end else begin
      state_q    <= state_d;
      div_q      <= div_d;
      cnt_q      <= cnt_d;
      bit_q      <= bit_d;
      sar_q      <= sar_d;
      result_q   <= result_d;
      busy_q     <= busy_d;
      sample_q   <= sample_d;
      dac_code_q <= sar_d;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic [5:0] h_ticks_q;
  logic [6:0] h_gap_q;
  logic       h_seen_q;

  // Helper counters: ticks since conversion start and cycles between ticks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_ticks_q <= 6'h00;
      h_gap_q   <= 7'h00;
      h_seen_q  <= 1'b0;
    end else if (!busy_q) begin
      h_ticks_q <= 6'h00;
      h_gap_q   <= 7'h00;
      h_seen_q  <= 1'b0;
    end else begin
      h_ticks_q <= tick ? h_ticks_q + 6'h01 : h_ticks_q;
      h_gap_q   <= tick ? 7'h00 : h_gap_q + 7'h01;
      h_seen_q  <= h_seen_q || tick;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  len_ext_a: assert property (done && src_sel_q != `ACS_SRC_TEMP |->
    h_ticks_q == `ACS_TOTAL_EXT - 6'h01) else $error("external conversion length wrong");
  len_temp_a: assert property (done && src_sel_q == `ACS_SRC_TEMP |->
    h_ticks_q == `ACS_TOTAL_TEMP - 6'h01) else $error("sensor conversion length wrong");
  bus_live_a: assert property (busy_q && avs_read && wait_q |=>
    !avs_waitrequest) else $error("bus stalled during conversion");
  pwr_gate_a: assert property (!pwr_en_q |-> !busy_q && !sample_q)
    else $error("converter active while powered down");
  start_hold_a: assert property (start_q |-> !busy_q)
    else $error("converter not held in reset by start");
  start_go_a: assert property (ctl0_wr && start_q &&
    avs_writedata[`ACS_B_START +: 3] == 3'b100 |=> busy_q ##1 busy_q)
    else $error("start release did not begin conversion");
  result_a: assert property (done |=> !busy_q && result_q == $past(res_fin))
    else $error("result not stored at completion");
  flag_set_a: assert property ($fell(busy_q) && $past(!start_set && pwr_d) |->
    flag_q) else $error("request flag not set at completion");
  tick_gap_a: assert property (tick && h_seen_q |->
    h_gap_q == 7'(acs_ratio(ckdiv_q) - 8'h01)) else $error("converter clock ratio wrong");
  ref_sel_a: assert property (ref_q[0] |-> ref_en_q == 3'b010)
    else $error("supply reference not selected");
  map_off_a: assert property (!map_q |=> tbl_data_q == 8'h00)
    else $error("calibration visible while unmapped");

endmodule
